// *** logic/fepc_pkg.sv ***
// package for the flash erase and protect controller: map, codes, timing
package fepc_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] PAGE_ADDR   = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] MASK_ADDR   = 8'h0C;
  localparam logic [7:0] OPTION_ADDR = 8'h10;
  localparam logic [7:0] RSVD_ADDR   = 8'h14;
  // reserved option byte location in program memory, always reads ones
  localparam logic [15:0] RSVD_OPT_LOC = 16'h0001;
  localparam logic [7:0]  RSVD_OPT_VAL = 8'hFF;
  // command codes
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8C;
  localparam logic [7:0] CMD_PAGE    = 8'h95;
  localparam logic [7:0] CMD_MASS    = 8'h63;
  localparam logic [7:0] CMD_BYPASS  = 8'hA5;
  // flash geometry
  localparam int PAGE_BYTES  = 512;
  localparam int FLASH_PAGES = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // ctrl fields
  localparam int CTRL_BYPASS_BIT = 8;
  localparam int CTRL_DEBUG_BIT  = 9;
  // status fields
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_UNLOCK_BIT = 1;
  localparam int ST_PDONE_BIT  = 2;
  localparam int ST_MDONE_BIT  = 3;
  localparam int ST_REFUSE_BIT = 4;
  // option fields
  localparam int OPT_GWP_BIT = 0;
  localparam int OPT_HSW_BIT = 1;
  localparam logic [1:0] OPT_RESET = 2'b00;
  // erase times
  localparam int CLK_MHZ       = 20;
  localparam int PAGE_ERASE_US = 10;
  localparam int MASS_ERASE_US = 200;
  localparam int PAGE_CYCLES   = PAGE_ERASE_US * CLK_MHZ;
  localparam int MASS_CYCLES   = MASS_ERASE_US * CLK_MHZ;
  // operation kinds
  typedef enum logic [1:0] {OP_PAGE = 2'b01, OP_MASS = 2'b10} fepc_op_t;
endpackage : fepc_pkg

// *** logic/fepc_timer.sv ***
// erase duration timer: pulses done after a loaded count
`timescale 1ns/100ps
`default_nettype none
module fepc_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] count,
  output logic                  done
);
  logic [WIDTH-1:0] cnt_reg;
  logic             run_reg;

  initial begin
    if (WIDTH < 2) $error("fepc_timer width too small");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= count;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end
endmodule : fepc_timer
`default_nettype wire

// *** logic/fepc_top.sv ***
// flash erase sequencer with write protection, bypass and axi4-lite registers
// Summary of operation
// (RQ1) page erase sets exactly one 512-byte page to FFH
// (RQ2) erased page is the page-select value when the command is written
// (RQ3) when unlocked, command 95H starts a page erase
// (RQ4) processor stalls during any erase; clock and peripherals keep running; in bypass the code holds cpu_stall low during pin erases
// (RQ5) debugger polls status until completion before further operations
// (RQ6) page erase end relocks the controller
// (RQ7) when unlocked, command 63H starts a mass erase
// (RQ8) mass erase sets every byte of the whole flash to FFH
// (RQ9) mass erase end relocks; completion visible in status
// (RQ10) software programs a byte at most twice between erases
// (RQ11) both protect bits zero: user erases refused, debugger mass erase allowed
// (RQ12) high-sector bit only: page erase in high sector only, no user mass erase
// (RQ13) global protect bit one: all erases allowed
// (RQ14) option byte at 0001H stays all ones, kept through reset
// (RQ15) bypass mode routes raw flash control signals to gpio pins
// (RQ16) page and mass erase stay achievable by external pins in bypass
// (RQ17) locked or protected erase commands are ignored, flash unchanged
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module fepc_top #(
  parameter int PAGE_W      = 6,
  parameter int HIGH_PAGES  = 2,
  parameter int PAGE_CYCLES = fepc_pkg::PAGE_CYCLES,
  parameter int MASS_CYCLES = fepc_pkg::MASS_CYCLES
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // flash array control
  output logic                   flash_page_erase,
  output logic                   flash_mass_erase,
  output logic [PAGE_W-1:0]      flash_page,
  // processor stall and interrupt
  output logic                   cpu_stall,
  output logic                   irq,
  // bypass: gpio-driven flash control and mirror out
  input  wire logic              gpio_page_erase,
  input  wire logic              gpio_mass_erase,
  input  wire logic [PAGE_W-1:0] gpio_page,
  output logic                   bypass_active
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PAGE = 3'b010,
    ST_MASS = 3'b100
  } fepc_state_t;

  localparam int TW = $clog2(MASS_CYCLES + 2);

  initial begin
    if (HIGH_PAGES < 1 || HIGH_PAGES > (1 << PAGE_W)) $error("bad high sector size");
    if (PAGE_CYCLES < 1 || MASS_CYCLES < 1) $error("erase times must be positive");
    // the timer is sized for the mass erase, so a longer page time would be cut short
    if (PAGE_CYCLES > MASS_CYCLES) $error("page erase time exceeds mass erase time");
  end

  fepc_state_t       state_reg;
  logic [1:0]        unlock_reg;
  logic [PAGE_W-1:0] page_reg;
  logic [1:0]        opt_reg;
  logic              bypass_reg;
  logic              debug_reg;
  logic [4:0]        status_reg;
  logic [4:0]        mask_reg;
  logic              aw_reg, w_reg;
  logic [7:0]        awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              timer_start;
  logic [TW-1:0]     timer_count;
  logic              timer_done;

  // high sector is the top HIGH_PAGES pages of the array
  function automatic logic in_high(input logic [PAGE_W-1:0] pg);
    in_high = (int'(pg) >= (1 << PAGE_W) - HIGH_PAGES);
  endfunction : in_high

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == fepc_pkg::CTRL_ADDR) || (a == fepc_pkg::PAGE_ADDR) ||
             (a == fepc_pkg::STATUS_ADDR) || (a == fepc_pkg::MASK_ADDR) ||
             (a == fepc_pkg::OPTION_ADDR) || (a == fepc_pkg::RSVD_ADDR);
  endfunction : mapped

  // write channel capture, either order
  wire wr_go = aw_reg && w_reg && !s_axi_bvalid;
  wire ctrl_wr = wr_go && awaddr_reg == fepc_pkg::CTRL_ADDR && wstrb_reg[0];
  wire [7:0] cmd = wdata_reg[7:0];
  wire idle = (state_reg == ST_IDLE) && !bypass_reg;
  wire unlocked = unlock_reg == 2'd2;
  wire gwp = opt_reg[fepc_pkg::OPT_GWP_BIT];
  wire hsw = opt_reg[fepc_pkg::OPT_HSW_BIT];
  wire page_ok = gwp || (hsw && in_high(page_reg)); // [RQ11] [RQ12] [RQ13]
  wire mass_ok = gwp || debug_reg;                   // [RQ11] [RQ12] [RQ13]
  wire page_cmd = ctrl_wr && cmd == fepc_pkg::CMD_PAGE;
  wire mass_cmd = ctrl_wr && cmd == fepc_pkg::CMD_MASS;
  wire go_page = idle && unlocked && page_cmd && page_ok; // [RQ3]
  wire go_mass = idle && unlocked && mass_cmd && mass_ok; // [RQ7]
  // commands during an erase are dropped silently: idle gates both go and refused
  wire refused = idle && (page_cmd && !go_page || mass_cmd && !go_mass); // [RQ17]
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire status_rd = rd_go && s_axi_araddr == fepc_pkg::STATUS_ADDR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg        <= 1'b0;
      w_reg         <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg        <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg        <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_reg       <= 1'b0;
        w_reg        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_reg) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: one outstanding read, answered the cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'b00;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        case (s_axi_araddr)
          fepc_pkg::CTRL_ADDR:   s_axi_rdata <= {22'h0, debug_reg, bypass_reg, 8'h00};
          fepc_pkg::PAGE_ADDR:   s_axi_rdata <= {{(32-PAGE_W){1'b0}}, page_reg};
          fepc_pkg::STATUS_ADDR: s_axi_rdata <= {27'h0, status_reg}; // [RQ5] [RQ9]
          fepc_pkg::MASK_ADDR:   s_axi_rdata <= {27'h0, mask_reg};
          fepc_pkg::OPTION_ADDR: s_axi_rdata <= {30'h0, opt_reg};
          fepc_pkg::RSVD_ADDR:   s_axi_rdata <= {24'h0, fepc_pkg::RSVD_OPT_VAL}; // [RQ14]
          default:               s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_reg   <= '0;
      opt_reg    <= fepc_pkg::OPT_RESET;
      bypass_reg <= 1'b0;
      debug_reg  <= 1'b0;
      mask_reg   <= '0;
    end else if (wr_go && wstrb_reg[0]) begin
      case (awaddr_reg)
        // page select is frozen while an erase runs so the target cannot move
        fepc_pkg::PAGE_ADDR:   if (state_reg == ST_IDLE) page_reg <= wdata_reg[PAGE_W-1:0];
        fepc_pkg::MASK_ADDR:   mask_reg <= wdata_reg[4:0];
        fepc_pkg::OPTION_ADDR: opt_reg <= wdata_reg[1:0];
        default:               ;
      endcase
      if (awaddr_reg == fepc_pkg::CTRL_ADDR && wstrb_reg[1] && state_reg == ST_IDLE) begin
        bypass_reg <= wdata_reg[fepc_pkg::CTRL_BYPASS_BIT]; // [RQ15]
        debug_reg  <= wdata_reg[fepc_pkg::CTRL_DEBUG_BIT];
      end
    end
  end

  // unlock sequence: two codes in order; anything else relocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_reg <= 2'd0;
    end else if (go_page || go_mass || refused) begin
      unlock_reg <= 2'd0; // [RQ6] [RQ9]
    end else if (ctrl_wr && idle) begin
      if (unlock_reg == 2'd0 && cmd == fepc_pkg::CMD_UNLOCK1) unlock_reg <= 2'd1;
      else if (unlock_reg == 2'd1 && cmd == fepc_pkg::CMD_UNLOCK2) unlock_reg <= 2'd2;
      else unlock_reg <= 2'd0;
    end
  end

  // erase sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go_page) state_reg <= ST_PAGE;
          else if (go_mass) state_reg <= ST_MASS;
        end
        ST_PAGE: if (timer_done) state_reg <= ST_IDLE;
        ST_MASS: if (timer_done) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign timer_start = go_page || go_mass;
  // both counts fit because the width follows the longer mass erase
  assign timer_count = go_mass ? TW'(MASS_CYCLES) : TW'(PAGE_CYCLES);

  fepc_timer #(.WIDTH(TW)) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (timer_start),
    .count   (timer_count),
    .done    (timer_done)
  );

  // sticky status: hardware set wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else begin
      status_reg[fepc_pkg::ST_BUSY_BIT]   <= state_reg != ST_IDLE || timer_start;
      status_reg[fepc_pkg::ST_UNLOCK_BIT] <= unlock_reg == 2'd2;
      if (status_rd) begin
        status_reg[fepc_pkg::ST_REFUSE_BIT:fepc_pkg::ST_PDONE_BIT] <= 3'b000;
      end
      if (timer_done && state_reg == ST_PAGE) status_reg[fepc_pkg::ST_PDONE_BIT] <= 1'b1;
      if (timer_done && state_reg == ST_MASS) status_reg[fepc_pkg::ST_MDONE_BIT] <= 1'b1;
      if (refused) status_reg[fepc_pkg::ST_REFUSE_BIT] <= 1'b1; // [RQ17]
    end
  end

  // flash control outputs; bypass hands them to gpio
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_page_erase <= 1'b0;
      flash_mass_erase <= 1'b0;
      flash_page       <= '0;
      cpu_stall        <= 1'b0;
      irq              <= 1'b0;
      bypass_active    <= 1'b0;
    end else begin
      bypass_active <= bypass_reg;
      irq           <= |(status_reg[4:2] & mask_reg[4:2]);
      if (bypass_reg) begin
        flash_page_erase <= gpio_page_erase; // [RQ15] [RQ16]
        flash_mass_erase <= gpio_mass_erase; // [RQ16]
        flash_page       <= gpio_page;
        cpu_stall        <= 1'b0;
      end else begin
        // erase strobe level lasts the whole erase; array clears the selected page
        flash_page_erase <= (state_reg == ST_PAGE) && !timer_done;           // [RQ1]
        flash_mass_erase <= (state_reg == ST_MASS) && !timer_done;           // [RQ8]
        if (go_page) flash_page <= page_reg;                                 // [RQ2]
        cpu_stall        <= (state_reg != ST_IDLE || timer_start) && !timer_done; // [RQ4]
      end
    end
  end
endmodule : fepc_top
`default_nettype wire

// *** testbench/fepc_checker.sv ***
// port assertions for the flash erase sequencer
`timescale 1ns/100ps
`default_nettype none
module fepc_checker #(
  parameter int PAGE_W = 6
) (
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic [31:0]       s_axi_rdata,
  // flash side
  input wire logic              flash_page_erase,
  input wire logic              flash_mass_erase,
  input wire logic [PAGE_W-1:0] flash_page,
  input wire logic              cpu_stall,
  input wire logic              bypass_active,
  input wire logic              gpio_page_erase
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic own_erase;
  assign own_erase = (flash_page_erase || flash_mass_erase) && !bypass_active;
  sequence s_page_go; $rose(flash_page_erase) && !bypass_active; endsequence
  sequence s_page_run; flash_page_erase [*3] ##[1:20] !flash_page_erase; endsequence
  sequence s_mass_go; $rose(flash_mass_erase) && !bypass_active; endsequence
  sequence s_mass_run; flash_mass_erase [*6] ##[1:30] !flash_mass_erase; endsequence
  a_stall_covers_erase: assert property (own_erase |-> cpu_stall)
    else $error("erase strobe without processor stall");
  a_stall_released: assert property ($fell(own_erase) |-> ##[0:4] !cpu_stall)
    else $error("processor still stalled after erase");
  a_page_held: assert property (own_erase && $past(own_erase) |-> $stable(flash_page))
    else $error("erase page moved during erase");
  a_page_length: assert property (s_page_go |-> s_page_run)
    else $error("page erase strobe length wrong");
  a_mass_length: assert property (s_mass_go |-> s_mass_run)
    else $error("mass erase strobe length wrong");
  a_one_erase_kind: assert property (!bypass_active |-> !(flash_page_erase && flash_mass_erase))
    else $error("page and mass erase together");
  a_bypass_mirror: assert property (bypass_active && $past(bypass_active, 2)
    && $past(gpio_page_erase) == $past(gpio_page_erase, 2) |-> flash_page_erase == $past(gpio_page_erase))
    else $error("bypass strobe does not follow pin");
  // address and data are registered first, so the response lands two edges after the handshake
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read with nonzero data");
endmodule : fepc_checker
bind fepc_top fepc_checker #(.PAGE_W(PAGE_W)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .flash_page_erase, .flash_mass_erase, .flash_page,
  .cpu_stall, .bypass_active, .gpio_page_erase);
`default_nettype wire

// *** testbench/fepc_flash_model.sv ***
// behavioural flash array driven by the erase strobes
`timescale 1ns/100ps
`default_nettype none
module fepc_flash_model #(
  parameter int PAGE_W = 6
) (
  // clock
  input wire logic              aclk,
  // erase control
  input wire logic              page_erase,
  input wire logic              mass_erase,
  input wire logic [PAGE_W-1:0] page
);
  localparam int PB = fepc_pkg::PAGE_BYTES;
  localparam int N  = fepc_pkg::FLASH_PAGES * PB;
  logic [7:0] mem [N];
  // a single program pass per erase keeps each byte under its program limit
  task automatic fill;
    for (int i = 0; i < N; i++) mem[i] = 8'h00;
    mem[fepc_pkg::RSVD_OPT_LOC] = fepc_pkg::RSVD_OPT_VAL;
  endtask : fill
  // one bit per page, set when every byte of it is erased
  function automatic logic [63:0] map;
    map = '1;
    for (int i = 0; i < N; i++) if (mem[i] !== 8'hFF) map[i / PB] = 1'b0;
  endfunction : map
  always @(posedge aclk) begin
    if (mass_erase) begin
      for (int i = 0; i < N; i++) mem[i] <= 8'hFF;
    end else if (page_erase) begin
      for (int j = 0; j < PB; j++) mem[int'(page) * PB + j] <= 8'hFF;
    end
  end
endmodule : fepc_flash_model
`default_nettype wire

// *** testbench/fepc_top_bench.sv ***
// self-checking bench for the flash erase sequencer
`timescale 1ns/100ps
`default_nettype none
module fepc_top_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, cpu_stall;
  logic flash_page_erase, flash_mass_erase, gpio_page_erase, gpio_mass_erase, bypass_active;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, st, last;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, wrsp;
  logic [5:0]  flash_page, gpio_page;
  int          n_mismatch, checks;
  fepc_top #(.PAGE_CYCLES(5), .MASS_CYCLES(10)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_page_erase,
    .flash_mass_erase, .flash_page, .cpu_stall, .irq, .gpio_page_erase, .gpio_mass_erase,
    .gpio_page, .bypass_active);
  fepc_flash_model flash (.aclk, .page_erase(flash_page_erase), .mass_erase(flash_mass_erase),
    .page(flash_page));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (s_axi_bvalid !== 1'b1) n_mismatch++;
    s_axi_bready <= 1'b0;
    wrsp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (s_axi_rvalid !== 1'b1) n_mismatch++;
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd
  // reads clear the sticky bits, so every poll result is collected
  task automatic poll;
    int n;
    n = 0;
    st = 0;
    do begin
      rd(fepc_pkg::STATUS_ADDR, last);
      st |= last;
      n++;
    end while ((last[0] !== 1'b0 || st[4:2] === 3'b000) && n < 100);
    if (last[0] !== 1'b0 || st[4:2] === 3'b000) n_mismatch++;
  endtask : poll
  task automatic op(input bit unlock, input logic [31:0] c);
    if (unlock) begin
      wr(fepc_pkg::CTRL_ADDR, {c[31:8], fepc_pkg::CMD_UNLOCK1});
      wr(fepc_pkg::CTRL_ADDR, {c[31:8], fepc_pkg::CMD_UNLOCK2});
    end
    wr(fepc_pkg::CTRL_ADDR, c);
    poll;
  endtask : op
  task automatic pins(input bit mass);
    @(posedge aclk);
    gpio_page <= 6'd5;
    if (mass) gpio_mass_erase <= 1'b1;
    else gpio_page_erase <= 1'b1;
    repeat (4) @(posedge aclk);
    gpio_page_erase <= 1'b0;
    gpio_mass_erase <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pins
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, gpio_page, gpio_page_erase, gpio_mass_erase} = '0;
    s_axi_wstrb = 4'hF;
    n_mismatch = 0;
    checks = 0;
    flash.fill();
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(fepc_pkg::OPTION_ADDR, d); chk("option reset", d, 64'h0);
    rd(fepc_pkg::RSVD_ADDR, d); chk("option byte", d, 64'hFF);
    rd(8'h18, d); chk("unmapped read", {rsp, d}, {2'b10, 32'h0});
    wr(8'h18, 32'h0); chk("unmapped write", wrsp, 64'h2);
    wr(fepc_pkg::MASK_ADDR, 32'h1C); chk("mask write", wrsp, 64'h0);
    wr(fepc_pkg::PAGE_ADDR, 32'd63);
    wr(fepc_pkg::CTRL_ADDR, fepc_pkg::CMD_PAGE);
    repeat (5) @(posedge aclk); chk("irq raised", irq, 64'h1);
    poll; chk("locked cmd", st[4:2], 64'h4);
    op(1, fepc_pkg::CMD_PAGE); chk("no protect page", st[4:2], 64'h4);
    chk("flash kept", flash.map(), 64'h0);
    wr(fepc_pkg::OPTION_ADDR, 32'h2);
    op(1, fepc_pkg::CMD_PAGE); chk("high page", st[4:2], 64'h1);
    chk("relock page", last[1], 64'h0);
    chk("one page", flash.map(), 64'h1 << 63);
    op(0, fepc_pkg::CMD_PAGE); chk("after relock", st[4:2], 64'h4);
    wr(fepc_pkg::PAGE_ADDR, 32'd10);
    op(1, fepc_pkg::CMD_PAGE); chk("low page", st[4:2], 64'h4);
    op(1, fepc_pkg::CMD_MASS); chk("user mass", st[4:2], 64'h4);
    wr(fepc_pkg::OPTION_ADDR, 32'h0);
    op(1, 32'h200 | fepc_pkg::CMD_MASS); chk("debug mass", st[4:2], 64'h2);
    chk("relock mass", last[1], 64'h0);
    chk("all erased", flash.map(), '1);
    wr(fepc_pkg::CTRL_ADDR, 32'h0);
    flash.fill();
    wr(fepc_pkg::OPTION_ADDR, 32'h1);
    wr(fepc_pkg::PAGE_ADDR, 32'd0);
    op(1, fepc_pkg::CMD_PAGE); chk("global page", st[4:2], 64'h1);
    chk("page zero", flash.map(), 64'h1);
    op(1, fepc_pkg::CMD_MASS); chk("global mass", st[4:2], 64'h2);
    chk("mass erased", flash.map(), '1);
    wr(fepc_pkg::MASK_ADDR, 32'h0);
    wr(fepc_pkg::CTRL_ADDR, fepc_pkg::CMD_PAGE);
    repeat (5) @(posedge aclk); chk("irq masked", irq, 64'h0);
    poll;
    flash.fill();
    wr(fepc_pkg::CTRL_ADDR, 32'h100);
    repeat (2) @(posedge aclk); chk("bypass on", bypass_active, 64'h1);
    pins(1'b0); chk("pin page", flash.map(), 64'h1 << 5);
    pins(1'b1); chk("pin mass", flash.map(), '1);
    wr(fepc_pkg::CTRL_ADDR, 32'h0);
    report_and_stop;
  end
endmodule : fepc_top_bench
`default_nettype wire
